/* File: core/ecg_gatekeeper.v */
// Purpose: Precondition checks and dispatch of the two enclave calls.
// Assumes: Processor state is loaded over APB before a check is started.
// Notes:   A write to the command register starts one check; the outcome
//          appears on the outputs two edges after the write is taken.
`timescale 1ns/100ps
`include "ecg_map.vh"

module ecg_gatekeeper (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         fault_valid,
  output reg  [2:0]  fault_code,
  output reg         vm_exit_valid,
  output reg         dispatch_valid,
  output reg  [31:0] dispatch_leaf,
  output reg         addr_width64
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg [20:0] state_q;
  reg [1:0]  feature_q;
  reg [5:0]  caps_q;
  reg [31:0] leaf_q;
  reg [63:0] bitmap_q;
  reg [6:0]  prefix_q;
  reg [23:0] opcode_q;
  reg        go_q;
  reg        done_q;
  reg [2:0]  code_q;
  reg        kind_user_q;
  reg        kind_hyper_q;

  wire       access;
  wire       wr_en;
  reg        mapped;
  reg [31:0] rdata;

  // A new access is taken once; the wait state lets prdata come from a flop.
  assign access = psel & penable & ~pready;
  assign wr_en  = access & pwrite;

  // ----------------------------------------------------------------------
  // State field views
  // ----------------------------------------------------------------------
  wire       pe      = state_q[`ECG_ST_PE];
  wire       vm      = state_q[`ECG_ST_VM];
  wire       system_management_state     = state_q[`ECG_ST_SMM];
  wire       pg      = state_q[`ECG_ST_PG];
  wire       ne      = state_q[`ECG_ST_NE];
  wire       ts      = state_q[`ECG_ST_TS];
  wire       lma     = state_q[`ECG_ST_LMA];
  wire       cs_l    = state_q[`ECG_ST_CSL];
  wire       cs_d    = state_q[`ECG_ST_CSD];
  wire       ds_down = state_q[`ECG_ST_DSDN];
  wire [1:0] current_privilege_level     = state_q[`ECG_ST_CPL_HI:`ECG_ST_CPL_LO];
  wire       in_encl = state_q[`ECG_ST_ENCL];
  wire       htx     = state_q[`ECG_ST_HTX];
  wire       u_ibt   = state_q[`ECG_ST_UIBT];
  wire       s_ibt   = state_q[`ECG_ST_SIBT];
  wire       u_wait  = state_q[`ECG_ST_UWAIT];
  wire       s_wait  = state_q[`ECG_ST_SWAIT];
  wire       vmx_op  = state_q[`ECG_ST_VMXOP];
  wire       nroot   = state_q[`ECG_ST_NROOT];
  wire       v_exec  = state_q[`ECG_ST_VEXEC];
  wire       fc_ok   = feature_q[`ECG_FC_LOCK] & feature_q[`ECG_FC_ENABLE];
  wire       base_ok = caps_q[`ECG_CAP_BASE];
  wire       oss_ok  = caps_q[`ECG_CAP_OSS];

  // ----------------------------------------------------------------------
  // Decode and derived conditions
  // ----------------------------------------------------------------------
  // full three-byte opcode match
  wire is_user  = (opcode_q == `ECG_OPC_USER);
  wire is_hyper = (opcode_q == `ECG_OPC_HYPER);

  wire mode64 = lma & cs_l;

  wire bad_pfx = prefix_q[`ECG_PF_LOCK] | prefix_q[`ECG_PF_OPSZ] |
                 prefix_q[`ECG_PF_REP] | prefix_q[`ECG_PF_VEX];

  // Level three is the only user level.
  wire user_lvl = (current_privilege_level == 2'h3);

  wire ibt_on   = user_lvl ? u_ibt : s_ibt;
  wire trk_wait = user_lvl ? u_wait : s_wait;

  wire [31:0] leaf = leaf_q;

  wire user_leaf_ok;
  wire hyper_leaf_ok;

  // Support lookups for each call kind.
  ecg_leaf_check u_user_leaf (
    .leaf  (leaf),
    .mask  (`ECG_USER_MASK),
    .valid (user_leaf_ok)
  );

  ecg_leaf_check u_hyper_leaf (
    .leaf  (leaf),
    .mask  (`ECG_HYPER_MASK),
    .valid (hyper_leaf_ok)
  );

  // Leaf classes used by the enclave-mode checks; a literal cannot be indexed, so name it.
  wire [15:0] outside_bad   = `ECG_OUTSIDE_BAD;
  wire        lf_inner_only = (leaf[31:4] == 28'h0000000) & outside_bad[leaf[3:0]];
  wire lf_outer_only = (leaf == `ECG_LEAF_ENTER) | (leaf == `ECG_LEAF_RESUME);

  // Exiting bitmap bit; leaves above the last slot share it.
  wire [5:0] bmap_idx = (leaf < `ECG_BMAP_LAST) ? leaf[5:0] : 6'h3f;
  wire       bmap_hit = bitmap_q[bmap_idx];

  // ----------------------------------------------------------------------
  // User call outcome
  // ----------------------------------------------------------------------
  reg [2:0] u_code;

  // Each check is tried in its fixed order; the first that hits wins.
  always @* begin
    u_code = `ECG_RC_PASS;
    if (htx) begin
      u_code = `ECG_RC_ABORT;
    end else if (ibt_on & trk_wait &
                 ((leaf != `ECG_LEAF_RESUME) | ts | system_management_state | ~base_ok | ~user_lvl)) begin
      u_code = `ECG_RC_CP;
    end else if (~pe | vm | system_management_state) begin
      u_code = `ECG_RC_UD;
    end else if (~base_ok) begin
      u_code = `ECG_RC_UD;
    end else if (bad_pfx) begin
      u_code = `ECG_RC_UD;
    end else if (ts) begin
      u_code = `ECG_RC_NM;
    end else if (~user_lvl) begin
      u_code = `ECG_RC_UD;
    end else if (~fc_ok) begin
      u_code = `ECG_RC_GP;
    end else if (~user_leaf_ok) begin
      u_code = `ECG_RC_GP;
    end else if (~pg | ~ne) begin
      u_code = `ECG_RC_GP;
    end else if (~mode64 & ~cs_d) begin
      u_code = `ECG_RC_GP;
    end else if (in_encl & lf_outer_only) begin
      u_code = `ECG_RC_GP;
    end else if (~in_encl & lf_inner_only) begin
      u_code = `ECG_RC_GP;
    end
  end

  // ----------------------------------------------------------------------
  // Hypervisor call outcome
  // ----------------------------------------------------------------------
  reg [2:0] v_code;

  // Same first-hit ordering for the hypervisor call.
  always @* begin
    v_code = `ECG_RC_PASS;
    if (htx) begin
      v_code = `ECG_RC_ABORT;
    end else if (~pe | vm | system_management_state | ~vmx_op) begin
      v_code = `ECG_RC_UD;
    end else if (~oss_ok) begin
      v_code = `ECG_RC_UD;
    end else if (bad_pfx) begin
      v_code = `ECG_RC_UD;
    end else if (current_privilege_level != 2'h0) begin
      v_code = `ECG_RC_UD;
    end else if (nroot & ~v_exec) begin
      v_code = `ECG_RC_UD;
    end else if (nroot & v_exec & bmap_hit) begin
      v_code = `ECG_RC_VMEXIT;
    end else if (~fc_ok) begin
      v_code = `ECG_RC_GP;
    end else if (~hyper_leaf_ok) begin
      v_code = `ECG_RC_GP;
    end else if (~pg) begin
      v_code = `ECG_RC_GP;
    end else if (~mode64 & ds_down) begin
      v_code = `ECG_RC_GP;
    end
  end

  // Final outcome; anything that is neither call is simply not ours.
  wire [2:0] eval_code = is_user  ? u_code :
                         is_hyper ? v_code : `ECG_RC_NOTENCL;

  // ----------------------------------------------------------------------
  // APB read decode
  // ----------------------------------------------------------------------
  // Unmapped offsets read zero and raise pslverr.
  always @* begin
    rdata  = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `ECG_OFF_STATE:   rdata = {11'h000, state_q};
      `ECG_OFF_FEATURE: rdata = {30'h00000000, feature_q};
      `ECG_OFF_CAPS:    rdata = {26'h0000000, caps_q};
      `ECG_OFF_LEAF:    rdata = leaf_q;
      `ECG_OFF_BMAP_LO: rdata = bitmap_q[31:0];
      `ECG_OFF_BMAP_HI: rdata = bitmap_q[63:32];
      `ECG_OFF_PREFIX:  rdata = {25'h0000000, prefix_q};
      `ECG_OFF_OPCODE:  rdata = {8'h00, opcode_q};
      `ECG_OFF_CMD:     rdata = 32'h00000000;
      `ECG_OFF_RESULT:  rdata = {25'h0000000, kind_hyper_q, kind_user_q,
                                 addr_width64, done_q, code_q};
      default:          mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB handshake and register writes
  // ----------------------------------------------------------------------
  // One wait state per access; writes to read-only words are dropped.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      state_q   <= `ECG_ST_RESET;
      feature_q <= 2'h0;
      caps_q    <= 6'h00;
      leaf_q    <= 32'h00000000;
      bitmap_q  <= 64'h0000000000000000;
      prefix_q  <= 7'h00;
      opcode_q  <= 24'h000000;
      go_q      <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      go_q    <= wr_en & (paddr == `ECG_OFF_CMD);
      if (access) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
      end
      if (wr_en) begin
        case (paddr)
          `ECG_OFF_STATE:   state_q   <= pwdata[20:0];
          `ECG_OFF_FEATURE: feature_q <= pwdata[1:0];
          `ECG_OFF_CAPS:    caps_q    <= pwdata[5:0];
          `ECG_OFF_LEAF:    leaf_q    <= pwdata;
          `ECG_OFF_BMAP_LO: bitmap_q[31:0]  <= pwdata;
          `ECG_OFF_BMAP_HI: bitmap_q[63:32] <= pwdata;
          // ignored prefixes kept only for readback
          `ECG_OFF_PREFIX:  prefix_q  <= pwdata[6:0];
          `ECG_OFF_OPCODE:  opcode_q  <= pwdata[23:0];
          default:          prefix_q  <= prefix_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Check result and pipeline outputs
  // ----------------------------------------------------------------------
  // The check runs the cycle after the command write, on settled registers.
  // A completion beats a command write that lands in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q         <= 1'b0;
      code_q         <= `ECG_RC_PASS;
      kind_user_q    <= 1'b0;
      kind_hyper_q   <= 1'b0;
      fault_valid    <= 1'b0;
      fault_code     <= `ECG_RC_PASS;
      vm_exit_valid  <= 1'b0;
      dispatch_valid <= 1'b0;
      dispatch_leaf  <= 32'h00000000;
      addr_width64   <= 1'b0;
    end else begin
      fault_valid    <= 1'b0;
      vm_exit_valid  <= 1'b0;
      dispatch_valid <= 1'b0;
      if (go_q) begin
        done_q        <= 1'b1;
        code_q        <= eval_code;
        kind_user_q   <= is_user;
        kind_hyper_q  <= is_hyper;
        fault_code    <= eval_code;
        addr_width64  <= mode64;
        fault_valid   <= (eval_code != `ECG_RC_PASS) &
                         (eval_code != `ECG_RC_VMEXIT);
        vm_exit_valid <= (eval_code == `ECG_RC_VMEXIT);
        dispatch_valid <= (eval_code == `ECG_RC_PASS);
        dispatch_leaf  <= leaf;
      end else if (wr_en & (paddr == `ECG_OFF_CMD)) begin
        done_q <= 1'b0;
      end
    end
  end

endmodule

/* File: core/ecg_leaf_check.v */
// Purpose: Tells whether a leaf index is defined and supported.
// Assumes: Leaves above 15 are never supported.
// Notes:   Pure combinational lookup against a support mask.
`timescale 1ns/100ps

module ecg_leaf_check (
  input  wire [31:0] leaf,
  input  wire [15:0] mask,
  output wire        valid
);

  // A leaf is valid only when small and marked in the support mask.
  assign valid = (leaf[31:4] == 28'h0000000) & mask[leaf[3:0]];

endmodule

/* File: inc/ecg_map.vh */
// Purpose: Offsets, field positions and codes of the enclave call gatekeeper.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Definitions only.
`ifndef ECG_MAP_VH
`define ECG_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ECG_OFF_STATE   8'h00
`define ECG_OFF_FEATURE 8'h04
`define ECG_OFF_CAPS    8'h08
`define ECG_OFF_LEAF    8'h0c
`define ECG_OFF_BMAP_LO 8'h10
`define ECG_OFF_BMAP_HI 8'h14
`define ECG_OFF_PREFIX  8'h18
`define ECG_OFF_OPCODE  8'h1c
`define ECG_OFF_CMD     8'h20
`define ECG_OFF_RESULT  8'h24

// ----------------------------------------------------------------------
// Processor state register fields
// ----------------------------------------------------------------------
`define ECG_ST_PE       0
`define ECG_ST_VM       1
`define ECG_ST_SMM      2
`define ECG_ST_PG       3
`define ECG_ST_NE       4
`define ECG_ST_TS       5
`define ECG_ST_LMA      6
`define ECG_ST_CSL      7
`define ECG_ST_CSD      8
`define ECG_ST_DSDN     9
`define ECG_ST_CPL_LO   10
`define ECG_ST_CPL_HI   11
`define ECG_ST_ENCL     12
`define ECG_ST_HTX      13
`define ECG_ST_UIBT     14
`define ECG_ST_SIBT     15
`define ECG_ST_UWAIT    16
`define ECG_ST_SWAIT    17
`define ECG_ST_VMXOP    18
`define ECG_ST_NROOT    19
`define ECG_ST_VEXEC    20
`define ECG_ST_WIDTH    21
`define ECG_ST_RESET    21'h000000

// Feature control and capability fields.
`define ECG_FC_LOCK     0
`define ECG_FC_ENABLE   1
`define ECG_CAP_BASE    0
`define ECG_CAP_OSS     5

// Prefix register fields.
`define ECG_PF_LOCK     0
`define ECG_PF_OPSZ     1
`define ECG_PF_REP      2
`define ECG_PF_VEX      3
`define ECG_PF_WIDTH    7

// ----------------------------------------------------------------------
// Opcodes, leaves and outcome codes
// ----------------------------------------------------------------------
`define ECG_OPC_USER    24'hd7010f
`define ECG_OPC_HYPER   24'hc0010f
`define ECG_LEAF_ENTER  32'h00000002
`define ECG_LEAF_RESUME 32'h00000003
`define ECG_OUTSIDE_BAD 16'h02b3
`define ECG_USER_MASK   16'h03ff
`define ECG_HYPER_MASK  16'h0007
`define ECG_BMAP_LAST   32'h0000003f

`define ECG_RC_PASS     3'h0
`define ECG_RC_ABORT    3'h1
`define ECG_RC_UD       3'h2
`define ECG_RC_NM       3'h3
`define ECG_RC_GP       3'h4
`define ECG_RC_CP       3'h5
`define ECG_RC_VMEXIT   3'h6
`define ECG_RC_NOTENCL  3'h7

`endif

/* File: verif/ecg_gatekeeper_checker.sv */
// Purpose: Port assertions for the enclave call gatekeeper.
// Assumes: A check outcome pulses two edges after its command write is taken.
// Notes:   Bound to every gatekeeper instance at the foot of this file.
`timescale 1ns/100ps
`include "ecg_map.vh"

module ecg_gatekeeper_checker (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic        pslverr,
  input logic        fault_valid,
  input logic [2:0]  fault_code,
  input logic        vm_exit_valid,
  input logic        dispatch_valid,
  input logic [31:0] dispatch_leaf,
  input logic        addr_width64
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A command write taken, and any outcome pulse.
  wire cmd_take = psel && penable && pwrite && !pready && (paddr == `ECG_OFF_CMD);
  wire any_out  = fault_valid || vm_exit_valid || dispatch_valid;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  chk_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow the first access cycle");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  chk_check_latency: assert property (cmd_take |-> ##2 any_out)
    else $error("no outcome two edges after a command");
  chk_no_stray: assert property (any_out |-> $past(cmd_take, 2))
    else $error("outcome pulse without a command");
  chk_one_outcome: assert property (
    $onehot0({fault_valid, vm_exit_valid, dispatch_valid}))
    else $error("more than one outcome at once");
  chk_pass_code: assert property (dispatch_valid |-> fault_code == 3'h0)
    else $error("dispatch with a fault code");
  chk_exit_code: assert property (vm_exit_valid |-> fault_code == 3'h6)
    else $error("exit pulse with a wrong code");
  chk_fault_code: assert property (
    fault_valid |-> fault_code != 3'h0 && fault_code != 3'h6)
    else $error("fault pulse with a non-fault code");
  chk_result_hold: assert property (
    !any_out |-> $stable(fault_code) && $stable(dispatch_leaf) && $stable(addr_width64))
    else $error("outcome changed between checks");
  chk_pulse_once: assert property (dispatch_valid |=> !dispatch_valid)
    else $error("dispatch pulse longer than one cycle");

  // Main scenarios reached.
  cov_dispatch: cover property (dispatch_valid);
  cov_exit:     cover property (vm_exit_valid);
  cov_track:    cover property (fault_valid && fault_code == 3'h5);
endmodule

bind ecg_gatekeeper ecg_gatekeeper_checker u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .fault_valid(fault_valid), .fault_code(fault_code),
  .vm_exit_valid(vm_exit_valid), .dispatch_valid(dispatch_valid),
  .dispatch_leaf(dispatch_leaf), .addr_width64(addr_width64));

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the enclave call gatekeeper.
// Assumes: State bits as laid out in the register map header.
// Notes:   A reference function predicts every outcome code.
`timescale 1ns/100ps
`include "ecg_map.vh"

module tb_top;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, fc, cap, pf, lf, rd;
  wire [31:0] prdata, dispatch_leaf;
  wire [2:0]  fault_code;
  wire        pready, pslverr, fault_valid, vm_exit_valid, dispatch_valid, addr_width64;
  reg  [20:0] st;
  reg  [63:0] bm;
  reg  [23:0] opc;
  reg         er;
  integer     seed, mismatches, samples_checked, i, k;

  ecg_gatekeeper u_ecg_gatekeeper (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_valid(fault_valid), .fault_code(fault_code),
    .vm_exit_valid(vm_exit_valid), .dispatch_valid(dispatch_valid),
    .dispatch_leaf(dispatch_leaf), .addr_width64(addr_width64));

  // Clock of 5 ns period.
  always #2.5 pclk = ~pclk;

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task cmp(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // One APB transfer; pready is taken at rising edges and the request held until it is seen.
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1) begin
        mismatches = mismatches + 1;
        $display("Error pready expected 1 seen %b", pready);
        stop_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask

  // Reference outcome from the current stimulus values.
  function [2:0] model_rc(input [31:0] l);
    reg c3, trk, pfx, n64;
    begin
      c3  = (st[11:10] == 2'd3);
      trk = c3 ? (st[14] & st[16]) : (st[15] & st[17]);
      pfx = |pf[3:0];
      n64 = !(st[6] & st[7]);
      if (opc == `ECG_OPC_USER) begin
        if (st[13]) model_rc = 3'h1;
        else if (trk && (l != 3 || st[5] || st[2] || !cap[0] || !c3)) model_rc = 3'h5;
        else if (!st[0] || st[1] || st[2] || !cap[0] || pfx) model_rc = 3'h2;
        else if (st[5]) model_rc = 3'h3;
        else if (!c3) model_rc = 3'h2;
        else if (fc[1:0] != 2'b11 || l > 9 || !st[3] || !st[4] || (n64 && !st[8])
                 || (st[12] && (l == 2 || l == 3))
                 || (!st[12] && ((16'h02b3 >> l[3:0]) & 16'h1))) model_rc = 3'h4;
        else model_rc = 3'h0;
      end else if (opc == `ECG_OPC_HYPER) begin
        if (st[13]) model_rc = 3'h1;
        else if (!st[0] || st[1] || st[2] || !st[18] || !cap[5] || pfx || st[11:10] != 2'd0
                 || (st[19] && !st[20])) model_rc = 3'h2;
        else if (st[19] && bm[(l < 63) ? l[5:0] : 6'd63]) model_rc = 3'h6;
        else if (fc[1:0] != 2'b11 || l > 2 || !st[3] || (n64 && st[9])) model_rc = 3'h4;
        else model_rc = 3'h0;
      end else model_rc = 3'h7;
    end
  endfunction

  // Load all state, start one check and compare every result.
  task go;
    reg [2:0] ec;
    begin
      ec = model_rc(lf);
      apb(`ECG_OFF_STATE, 1'b1, {11'h0, st});
      apb(`ECG_OFF_FEATURE, 1'b1, fc);
      apb(`ECG_OFF_CAPS, 1'b1, cap);
      apb(`ECG_OFF_LEAF, 1'b1, lf);
      apb(`ECG_OFF_BMAP_LO, 1'b1, bm[31:0]);
      apb(`ECG_OFF_BMAP_HI, 1'b1, bm[63:32]);
      apb(`ECG_OFF_PREFIX, 1'b1, pf);
      apb(`ECG_OFF_OPCODE, 1'b1, {8'h00, opc});
      apb(`ECG_OFF_CMD, 1'b1, 32'h00000001);
      @(negedge pclk);
      cmp("code", {29'h0, ec}, {29'h0, fault_code});
      cmp("valids", {ec == 0, ec == 6, ec != 0 && ec != 6},
          {dispatch_valid, vm_exit_valid, fault_valid});
      cmp("leaf", lf, dispatch_leaf);
      cmp("width64", st[6] & st[7], addr_width64);
      apb(`ECG_OFF_RESULT, 1'b0, 32'h0);
      cmp("result", {opc == `ECG_OPC_HYPER, opc == `ECG_OPC_USER, st[6] & st[7], 1'b1, ec},
          rd[6:0]);
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; seed = 32'h887dc53b;
    mismatches = 0; samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(`ECG_OFF_STATE, 1'b0, 32'h0);
    cmp("st_reset", 32'h0, rd);
    apb(8'h28, 1'b0, 32'h0);
    cmp("unmap_err", 32'h1, {31'h0, er});
    cmp("unmap_rd", 32'h0, rd);
    fc = 32'h3; cap = 32'h21; pf = 32'h0; bm = 64'h0; opc = `ECG_OPC_USER;
    // Every user leaf inside and outside an enclave.
    for (k = 0; k < 24; k = k + 1) begin
      st = 21'h000d19 | ((k / 12) << 12);
      lf = k % 12;
      go;
    end
    // Clean resume under branch tracking, then a plain leaf under it.
    st = 21'h014d19; lf = 3;
    go;
    lf = 6;
    go;
    // Each prefix bit on both calls.
    for (k = 0; k < 14; k = k + 1) begin
      st = (k < 7) ? 21'h000d19 : 21'h140009;
      opc = (k < 7) ? `ECG_OPC_USER : `ECG_OPC_HYPER;
      pf = 32'h1 << (k % 7); lf = 0;
      go;
    end
    // Exit bitmap: last bit covers every leaf above 62.
    st = 21'h1c0009; pf = 0; bm = 64'h8000000000000002;
    for (k = 0; k < 4; k = k + 1) begin
      lf = (k == 3) ? 32'h00000070 : k;
      go;
    end
    // Random states near a passing call, opcode picked at random.
    for (i = 0; i < 250; i = i + 1) begin
      k = {$random(seed)} % 8;
      opc = (k < 4) ? `ECG_OPC_USER : (k < 7) ? `ECG_OPC_HYPER : 24'hcf010f;
      st = ((k < 4) ? 21'h000d19 : 21'h140009) ^ ($random(seed) & 21'h0812c0);
      if ($random(seed) & 1) st = st ^ (21'h1 << ({$random(seed)} % 21));
      fc = ($random(seed) & 7) ? 32'h3 : $random(seed);
      cap = ($random(seed) & 7) ? 32'h21 : $random(seed);
      pf = ($random(seed) & 7) ? ($random(seed) & 32'h70) : $random(seed);
      lf = ($random(seed) & 15) ? ({$random(seed)} % 12) : $random(seed);
      bm = {$random(seed), $random(seed)};
      go;
    end
    stop_test;
  end
endmodule
